// ===== common/bleint_pkg.sv
// package: register map, field positions, timing for line event interrupts
`default_nettype none
package bleint_pkg;
    // register addresses (5-bit register index)
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_LATCH_SET = 5'h0a;
    localparam logic [4:0] ADDR_LATCH_CLR = 5'h0b;
    localparam logic [4:0] ADDR_FALL_SET = 5'h0c;
    localparam logic [4:0] ADDR_FALL_CLR = 5'h0d;
    localparam logic [4:0] ADDR_RISE_SET = 5'h0e;
    localparam logic [4:0] ADDR_RISE_CLR = 5'h0f;
    localparam logic [4:0] ADDR_TIMER_SET = 5'h18;
    localparam logic [4:0] ADDR_TIMER_CLR = 5'h19;
    // source bit positions
    localparam int BIT_CARKIT_DP = 7;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_ID_OPEN = 5;
    localparam int BIT_SE1 = 4;
    localparam int BIT_ID_GROUND = 3;
    localparam int BIT_DP_LEVEL = 2;
    localparam int BIT_SESSION = 1;
    localparam int BIT_VBUS_HIGH = 0;
    // writable bits (bit 6 reserved)
    localparam logic [7:0] SRC_MASK = 8'hbf;
    // reset values
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] TIMER_RESET = 8'h10;
    // timer field position
    localparam int TMR_LSB = 4;
    // timing: 1 ms unit at 20 MHz
    localparam int CLK_HZ = 20000000;
    localparam int UNIT_US = 1000;
    localparam int UNIT_CYCLES = CLK_HZ / 1000000 * UNIT_US;

    typedef struct packed {
        logic carkitDpThreshold;
        logic idPinOpen;
        logic se1Raw;
        logic idPinGrounded;
        logic dpReceiverLevel;
        logic sessionValid;
        logic vbusHighDetect;
    } bleint_detect_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } bleint_req_type;
endpackage
`default_nettype wire

// ===== rtl/bleint_se1_timer.sv
// se1 qualification timer: raw se1 must persist for the programmed period
`default_nettype none
module bleint_se1_timer
    import bleint_pkg::*;
#(
    parameter int UNIT_COUNT = UNIT_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic se1Raw,
    input wire logic [3:0] se1PeriodTimer,
    // result
    output logic se1Detected
);
    logic [15:0] unitCnt_q;
    logic [3:0] unitsDone_q;
    logic se1Det_q;
    logic unitTick;
    logic [3:0] target;

    assign unitTick = (unitCnt_q == 16'(UNIT_COUNT - 1));
    assign target = (se1PeriodTimer == 4'h0) ? 4'h1 : se1PeriodTimer;
    assign se1Detected = se1Det_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            unitCnt_q <= 16'h0000;
            unitsDone_q <= 4'h0;
            se1Det_q <= 1'b0;
        end
        else if (!se1Raw)
        begin
            unitCnt_q <= 16'h0000;
            unitsDone_q <= 4'h0;
            se1Det_q <= 1'b0;
        end
        else if (!se1Det_q)
        begin
            unitCnt_q <= unitTick ? 16'h0000 : unitCnt_q + 16'h0001;
            if (unitTick)
            begin
                unitsDone_q <= unitsDone_q + 4'h1;
                se1Det_q <= (unitsDone_q + 4'h1 >= target);
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/bleint_core.sv
// line event interrupt block: source, latch, edge enables, se1 timer
`default_nettype none
// Overview of operation
// - status bit 7 shows carkit DP above interrupt threshold
// - status bit 5 shows identification pin floating
// - status bit 4 is 1 after SE1 persists for timer period
// - status bit 3 shows identification pin grounded
// - status bit 2 follows DP single-ended receiver level
// - read-only live status at address 08h, bit 6 reserved
// - latch holds one event bit per source at the status position
// - latch set 0Ah, clear 0Bh, both read it, resets to zero
// - falling edge with falling enable sets the latch bit
// - falling enable at set 0Ch, clear 0Dh, resets zero, bit 6 reserved
// - rising enable at 0Eh/0Fh; rising edge with enable sets latch
// - writing one at latch set address sets that bit directly
// - SE1 period programmable in 1 ms units, four bits, default 1 ms
module bleint_core
    import bleint_pkg::*;
#(
    parameter int UNIT_COUNT = UNIT_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // detector inputs
    input wire bleint_detect_type detect,
    // register access
    input wire bleint_req_type req,
    output logic [7:0] rdata,
    // interrupt to host
    output logic intReq
);
    logic [7:0] status_q;
    logic [7:0] latch_q;
    logic [7:0] fallEn_q;
    logic [7:0] riseEn_q;
    logic [7:0] timer_q;
    logic [7:0] rdata_q;
    logic intReq_q;
    logic se1Detected;
    logic [7:0] statusNow;
    logic [7:0] fellEvents;
    logic [7:0] roseEvents;
    logic [7:0] wrMask;
    logic [7:0] readMux;
    logic [7:0] latchNext;
    logic [7:0] fallNext;
    logic [7:0] riseNext;
    logic [7:0] timerNext;
    logic wrLatchSet;
    logic wrLatchClr;
    logic wrFallSet;
    logic wrFallClr;
    logic wrRiseSet;
    logic wrRiseClr;
    logic wrTimerSet;
    logic wrTimerClr;
    logic rdStatus;
    logic rdLatch;
    logic rdFall;
    logic rdRise;
    logic rdTimer;

    function automatic logic [7:0] setClr(input logic [7:0] cur, input logic doSet,
        input logic doClr, input logic [7:0] bits);
        logic [7:0] r;
        r = cur;
        if (doSet)
            r = cur | bits;
        if (doClr)
            r = cur & ~bits;
        return r;
    endfunction

    // write strobe for one register address
    function automatic logic wrHit(input bleint_req_type r, input logic [4:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // read select for a set/clear address pair
    function automatic logic regHit(input logic [4:0] a, input logic [4:0] setAddr,
        input logic [4:0] clrAddr);
        return (a == setAddr) || (a == clrAddr);
    endfunction

    bleint_se1_timer #(.UNIT_COUNT(UNIT_COUNT)) u_se1 (
        .mclk(mclk),
        .rst(rst),
        .se1Raw(detect.se1Raw),
        .se1PeriodTimer(timer_q[TMR_LSB +: 4]),
        .se1Detected(se1Detected)
    );

    // live source vector
    assign statusNow[BIT_CARKIT_DP] = detect.carkitDpThreshold;
    assign statusNow[BIT_RESERVED] = 1'b0;
    assign statusNow[BIT_ID_OPEN] = detect.idPinOpen;
    assign statusNow[BIT_SE1] = se1Detected;
    assign statusNow[BIT_ID_GROUND] = detect.idPinGrounded;
    assign statusNow[BIT_DP_LEVEL] = detect.dpReceiverLevel;
    assign statusNow[BIT_SESSION] = detect.sessionValid;
    assign statusNow[BIT_VBUS_HIGH] = detect.vbusHighDetect;

    // edge detection on the registered status
    assign fellEvents = status_q & ~statusNow & fallEn_q;
    assign roseEvents = ~status_q & statusNow & riseEn_q;
    assign wrMask = req.wdata & SRC_MASK;

    // write strobes per address
    assign wrLatchSet = wrHit(req, ADDR_LATCH_SET);
    assign wrLatchClr = wrHit(req, ADDR_LATCH_CLR);
    assign wrFallSet = wrHit(req, ADDR_FALL_SET);
    assign wrFallClr = wrHit(req, ADDR_FALL_CLR);
    assign wrRiseSet = wrHit(req, ADDR_RISE_SET);
    assign wrRiseClr = wrHit(req, ADDR_RISE_CLR);
    assign wrTimerSet = wrHit(req, ADDR_TIMER_SET);
    assign wrTimerClr = wrHit(req, ADDR_TIMER_CLR);

    // next values of the set/clear registers
    assign fallNext = setClr(fallEn_q, wrFallSet, wrFallClr, wrMask);
    assign riseNext = setClr(riseEn_q, wrRiseSet, wrRiseClr, wrMask);
    assign timerNext = setClr(timer_q, wrTimerSet, wrTimerClr, req.wdata & 8'hf0);

    // hardware events win over a same-cycle clear
    assign latchNext = setClr(latch_q, wrLatchSet, wrLatchClr, wrMask)
        | fellEvents | roseEvents;

    // read decode
    assign rdStatus = (req.addr == ADDR_STATUS);
    assign rdLatch = regHit(req.addr, ADDR_LATCH_SET, ADDR_LATCH_CLR);
    assign rdFall = regHit(req.addr, ADDR_FALL_SET, ADDR_FALL_CLR);
    assign rdRise = regHit(req.addr, ADDR_RISE_SET, ADDR_RISE_CLR);
    assign rdTimer = regHit(req.addr, ADDR_TIMER_SET, ADDR_TIMER_CLR);
    assign readMux =
        rdStatus ? status_q :
        rdLatch ? latch_q :
        rdFall ? fallEn_q :
        rdRise ? riseEn_q :
        rdTimer ? timer_q :
        8'h00;

    assign rdata = rdata_q;
    assign intReq = intReq_q;

    // registered source snapshot for edge detection
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            status_q <= 8'h00;
        end
        else
        begin
            status_q <= statusNow;
        end
    end

    // event latch
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            latch_q <= LATCH_RESET;
        end
        else
        begin
            latch_q <= latchNext;
        end
    end

    // falling-edge enables
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fallEn_q <= ENABLE_RESET;
        end
        else
        begin
            fallEn_q <= fallNext;
        end
    end

    // rising-edge enables
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            riseEn_q <= ENABLE_RESET;
        end
        else
        begin
            riseEn_q <= riseNext;
        end
    end

    // se1 period field
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            timer_q <= TIMER_RESET;
        end
        else
        begin
            timer_q <= timerNext;
        end
    end

    // read data holds until the next read
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= 8'h00;
        end
        else if (req.rd)
        begin
            rdata_q <= readMux;
        end
    end

    // interrupt request follows the latch
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            intReq_q <= 1'b0;
        end
        else
        begin
            intReq_q <= |latchNext;
        end
    end
endmodule
`default_nettype wire

// ===== verif/bleint_core_props.sv
// checker: port relations of the line event block
`default_nettype none
module bleint_core_props
    import bleint_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // block ports
    input wire bleint_detect_type detect,
    input wire bleint_req_type req,
    input wire logic [7:0] rdata,
    input wire logic intReq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    status_read_a:
        assert property (req.rd && req.addr == 5'h08 && !$past(rst) |=> {rdata[7:5], rdata[3:0]}
            == {$past(detect[6], 2), 1'b0, $past(detect[5], 2), $past(detect[3:0], 2)})
        else $error("status read");
    unmapped_read_a:
        assert property (req.rd && req.addr == 5'h1f |=> rdata == 8'h00)
        else $error("unmapped read");
    reserved_bit_a:
        assert property (req.rd && req.addr < 5'h10 |=> !rdata[6])
        else $error("bit six set");
    set_raises_a:
        assert property (req.wr && req.addr == 5'h0a && req.wdata[0] |=> intReq)
        else $error("set no irq");
    clear_drops_a:
        assert property (req.wr && req.addr == 5'h0b && req.wdata == 8'hff && $stable(detect)
            && !detect.se1Raw && !$past(detect.se1Raw, 2) |=> !intReq)
        else $error("clear kept irq");
    irq_cause_a:
        assert property ($rose(intReq) |-> $past(req.wr) || $past(detect) != $past(detect, 2)
            || $past(detect.se1Raw, 2) || $past(detect.se1Raw, 3))
        else $error("irq no cause");
    irq_release_a:
        assert property ($fell(intReq) |-> $past(req.wr) || $past(req.wr, 2))
        else $error("irq fell alone");
    rdata_hold_a:
        assert property (!req.rd |=> $stable(rdata))
        else $error("rdata moved");
endmodule
bind bleint_core bleint_core_props bleint_core_props_inst (.mclk(mclk), .rst(rst),
    .detect(detect), .req(req), .rdata(rdata), .intReq(intReq));
`default_nettype wire

// ===== verif/bleint_host_model.sv
// host model: one request per call on the register port
`default_nettype none
module bleint_host_model
    import bleint_pkg::*;
(
    // clock
    input wire logic mclk,
    // register port
    output bleint_req_type req,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge mclk);
        req <= '{rd: rd, wr: !rd, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// ===== verif/test_bus_line_event_interrupts.sv
// testbench: line event interrupt block
`default_nettype none
module test_bus_line_event_interrupts import bleint_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    bleint_detect_type detect = '0;
    bleint_req_type req;
    logic [7:0] rdata;
    logic intReq;
    logic [7:0] q;
    int n_fail = 0;
    int n_tests = 0;
    initial forever #25 mclk = ~mclk;
    bleint_core #(.UNIT_COUNT(5)) bleint_core_inst (.mclk(mclk), .rst(rst), .detect(detect),
        .req(req), .rdata(rdata), .intReq(intReq));
    bleint_host_model bleint_host_model_inst (.mclk(mclk), .req(req), .rdata(rdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [4:0] a, input logic [7:0] d);
        bleint_host_model_inst.xfer(1'b0, a, d, q);
    endtask
    task automatic r(input logic [4:0] a, input logic [7:0] exp);
        bleint_host_model_inst.xfer(1'b1, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic drive(input logic [6:0] v);
        @(posedge mclk);
        detect <= v;
        repeat (2) @(posedge mclk);
    endtask
    task automatic t_status;
        w(5'h08, 8'hff);
        for (int i = 0; i < 7; i++)
        begin
            drive(7'h01 << i);
            if (i != 4)
                r(5'h08, i == 6 ? 8'h80 : 8'h01 << i);
        end
        drive(7'h00);
        r(5'h0a, 8'h00);
    endtask
    task automatic t_fall;
        w(5'h0c, 8'hff);
        r(5'h0d, 8'hbf);
        drive(7'h6f);
        drive(7'h00);
        r(5'h0b, 8'haf);
        chk({7'h00, intReq}, 8'h01);
        w(5'h0b, 8'h0f);
        r(5'h0a, 8'ha0);
        w(5'h0b, 8'ha0);
        w(5'h0d, 8'hff);
        r(5'h0c, 8'h00);
        chk({7'h00, intReq}, 8'h00);
    endtask
    task automatic t_rise;
        w(5'h0e, 8'h04);
        drive(7'h04);
        r(5'h0a, 8'h04);
        w(5'h0f, 8'h04);
        w(5'h0b, 8'hff);
        drive(7'h00);
        w(5'h0a, 8'hff);
        r(5'h0b, 8'hbf);
        w(5'h0b, 8'hff);
    endtask
    task automatic t_reset;
        r(5'h0a, 8'h00);
        r(5'h0c, 8'h00);
        r(5'h0e, 8'h00);
        r(5'h18, 8'h10);
        r(5'h1f, 8'h00);
        chk({7'h00, intReq}, 8'h00);
    endtask
    task automatic t_se1;
        w(5'h19, 8'hf0);
        w(5'h18, 8'h2f);
        r(5'h19, 8'h20);
        w(5'h0e, 8'h10);
        drive(7'h10);
        r(5'h08, 8'h00);
        repeat (4) @(posedge mclk);
        r(5'h08, 8'h00);
        chk({7'h00, intReq}, 8'h01);
        r(5'h08, 8'h10);
        r(5'h0a, 8'h10);
        drive(7'h00);
        r(5'h08, 8'h00);
        w(5'h0b, 8'hff);
    endtask
    task automatic summarize;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_status;
        t_fall;
        t_rise;
        t_se1;
        summarize;
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        summarize;
    end
endmodule
`default_nettype wire
